// [fdr_bus_sink.sv]
// model of the blind actuators: takes telegrams and logs them in order
// assumes tel and tel_valid come from the block on sys_clk
`timescale 1ns/1ps
module fdr_bus_sink (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              slow,
    input  wire logic              tel_valid,
    input  wire fdr_pkg::fdr_tel_t tel,
    output logic                   tel_ready
);
    // ************************************************************
    // acceptance and log
    // ************************************************************
    logic              phase_q;
    fdr_pkg::fdr_tel_t got [0:15];
    int                n_got;

    // slow mode accepts only every second cycle
    assign tel_ready = !slow || phase_q;

    // log each accepted telegram
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_q <= 1'b0;
            n_got   <= 0;
        end
        else
        begin
            phase_q <= ~phase_q;
            if (tel_valid && tel_ready)
            begin
                got[n_got % 16] <= tel;
                n_got           <= n_got + 1;
            end
        end
    end
endmodule : fdr_bus_sink

// [fdr_facade_disable.sv]
// facade disable response: lock handling and telegram generation for one facade
// assumes apb master and the telegram sink run on sys_clk; disable and automatic
// updates arrive as one-cycle strobes from logic on the same clock
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps

module fdr_facade_disable #(
    parameter int ADDR_W = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // disable object telegram
    input  wire logic        dis_valid,
    input  wire logic        dis_value,
    // automatic shading updates, one strobe per object
    input  wire logic [2:0]  auto_valid,
    input  wire logic [7:0]  auto_height,
    input  wire logic [7:0]  auto_shade,
    input  wire logic [7:0]  auto_slat,
    // telegram toward the bus
    output logic             tel_valid,
    input  wire logic        tel_ready,
    output fdr_pkg::fdr_tel_t tel,
    output logic             locked
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_chk
        $error("ADDR_W must lie between 4 and 32");
    end

    fdr_pkg::fdr_state_t s_q;
    fdr_pkg::fdr_state_t s_d;

    logic [7:0] addr8;
    logic       wr_en;
    logic       rd_setup;
    logic       mapped;
    logic       dis_lock;
    logic       lock_start;
    logic       lock_end;

    // ************************************************************
    // apb decode
    // ************************************************************
    // only the low byte of the address selects a register
    assign addr8    = 8'(paddr);
    assign mapped   = (addr8 == fdr_pkg::CTRL_OFS) || (addr8 == fdr_pkg::STARTV_OFS) ||
                      (addr8 == fdr_pkg::ENDV_OFS) || (addr8 == fdr_pkg::STATUS_OFS);
    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;                   // zero wait states
    assign pslverr  = psel && penable && !mapped;

    // lock decision from the disable telegram
    assign dis_lock   = (dis_value == s_q.ctrl.lock_on_one);
    assign lock_start = s_q.ctrl.enable && dis_valid && dis_lock && !s_q.locked;
    assign lock_end   = s_q.ctrl.enable && dis_valid && !dis_lock && s_q.locked;

    // saturate a written percentage at the ceiling
    function automatic logic [6:0] pct(input logic [7:0] v);
        pct = (v > {1'b0, fdr_pkg::PCT_MAX}) ? fdr_pkg::PCT_MAX : v[6:0];
    endfunction : pct

    // unpack a value register write
    function automatic fdr_pkg::fdr_vals_t vals_wr(input logic [31:0] w);
        vals_wr.height = pct(w[fdr_pkg::HEIGHT_LSB +: 8]);
        vals_wr.shade  = pct(w[fdr_pkg::SHADE_LSB +: 8]);
        vals_wr.slat   = pct(w[fdr_pkg::SLAT_LSB +: 8]);
        vals_wr.sbit   = w[fdr_pkg::SBIT_POS];
    endfunction : vals_wr

    // pack a value register for reading
    function automatic logic [31:0] vals_rd(input fdr_pkg::fdr_vals_t v);
        vals_rd = 32'h0;
        vals_rd[fdr_pkg::HEIGHT_LSB +: 8] = {1'b0, v.height};
        vals_rd[fdr_pkg::SHADE_LSB +: 8]  = {1'b0, v.shade};
        vals_rd[fdr_pkg::SLAT_LSB +: 8]   = {1'b0, v.slat};
        vals_rd[fdr_pkg::SBIT_POS]        = v.sbit;
    endfunction : vals_rd

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic [2:0]  set_pend;
        logic [23:0] set_data;
        logic [2:0]  take;
        s_d      = s_q;
        set_pend = 3'h0;
        set_data = 24'h0;
        take     = 3'h0;

        // register writes
        if (wr_en)
        begin
            case (addr8)
                fdr_pkg::CTRL_OFS:   s_d.ctrl   = fdr_pkg::fdr_ctrl_t'(pwdata[fdr_pkg::CTRL_W-1:0]);
                fdr_pkg::STARTV_OFS: s_d.startv = vals_wr(pwdata);
                fdr_pkg::ENDV_OFS:   s_d.endv   = vals_wr(pwdata);
                default:             s_d.ctrl   = s_q.ctrl;
            endcase
        end

        // read data captured in the setup phase
        if (rd_setup)
        begin
            case (addr8)
                fdr_pkg::CTRL_OFS:   s_d.prdata = {14'h0, s_q.ctrl};
                fdr_pkg::STARTV_OFS: s_d.prdata = vals_rd(s_q.startv);
                fdr_pkg::ENDV_OFS:   s_d.prdata = vals_rd(s_q.endv);
                fdr_pkg::STATUS_OFS: s_d.prdata = {s_q.cur_slat[6:0], s_q.cur_shade,
                                                   s_q.cur_height, 4'h0, s_q.pend,
                                                   s_q.seq == fdr_pkg::SEQ_BUSY, s_q.locked};
                default:             s_d.prdata = 32'h0;
            endcase
        end

        // automatic updates always refresh current values
        if (auto_valid[0])
        begin
            s_d.cur_height = auto_height;
        end
        if (auto_valid[1])
        begin
            s_d.cur_shade = auto_shade;
        end
        if (auto_valid[2])
        begin
            s_d.cur_slat = auto_slat;
        end
        // outside a lock each update is queued for sending, except in the cycle where a lock starts
        if (!s_q.locked)
        begin
            set_pend = auto_valid;
            set_data = {auto_slat, auto_shade, auto_height};
        end

        // lock tracking
        if (lock_start)
        begin
            s_d.locked = 1'b1;
        end
        if (lock_end || !s_q.ctrl.enable)
        begin
            s_d.locked = 1'b0;
        end

        // configured state at the start of a lock; track is not offered here
        if (lock_start && s_q.ctrl.st_cfg)
        begin
            set_pend = 3'h0;
            if (s_q.ctrl.height_byte && s_q.ctrl.st_height == fdr_pkg::CH_SEND)
            begin
                set_pend[0]     = 1'b1;
                set_data[7:0]   = {1'b0, s_q.startv.height};
            end
            if (s_q.ctrl.st_shade == fdr_pkg::CH_SEND)
            begin
                set_pend[1]     = 1'b1;
                set_data[15:8]  = s_q.ctrl.shade_byte ? {1'b0, s_q.startv.shade}
                                                      : {7'h0, s_q.startv.sbit};
            end
            if (s_q.ctrl.st_slat == fdr_pkg::CH_SEND)
            begin
                set_pend[2]     = 1'b1;
                set_data[23:16] = {1'b0, s_q.startv.slat};
            end
        end
        else if (lock_start)
        begin
            set_pend = 3'h0;
        end

        // configured state at the end of a lock, with tracking
        if (lock_end && s_q.ctrl.end_cfg)
        begin
            set_pend = 3'h0;
            if (s_q.ctrl.height_byte && s_q.ctrl.end_height == fdr_pkg::CH_SEND)
            begin
                set_pend[0]   = 1'b1;
                set_data[7:0] = {1'b0, s_q.endv.height};
            end
            else if (s_q.ctrl.height_byte && s_q.ctrl.end_height == fdr_pkg::CH_TRACK)
            begin
                set_pend[0]   = 1'b1;
                set_data[7:0] = s_d.cur_height;
            end
            if (s_q.ctrl.end_shade == fdr_pkg::CH_SEND)
            begin
                set_pend[1]    = 1'b1;
                set_data[15:8] = s_q.ctrl.shade_byte ? {1'b0, s_q.endv.shade}
                                                     : {7'h0, s_q.endv.sbit};
            end
            else if (s_q.ctrl.end_shade == fdr_pkg::CH_TRACK)
            begin
                set_pend[1]    = 1'b1;
                set_data[15:8] = s_q.ctrl.shade_byte ? s_d.cur_shade
                                                     : {7'h0, s_d.cur_shade[0]};
            end
            if (s_q.ctrl.end_slat == fdr_pkg::CH_SEND)
            begin
                set_pend[2]     = 1'b1;
                set_data[23:16] = {1'b0, s_q.endv.slat};
            end
            else if (s_q.ctrl.end_slat == fdr_pkg::CH_TRACK)
            begin
                set_pend[2]     = 1'b1;
                set_data[23:16] = s_d.cur_slat;
            end
        end
        else if (lock_end)
        begin
            set_pend = 3'h0;
        end

        // sequencer: lowest pending object first, one telegram at a time
        case (s_q.seq)
            fdr_pkg::SEQ_IDLE:
            begin
                if (s_q.pend[0])
                begin
                    take        = 3'b001;
                    s_d.tel.obj = fdr_pkg::OBJ_HEIGHT;
                    s_d.tel.data = s_q.pend_data_0;
                end
                else if (s_q.pend[1])
                begin
                    take        = 3'b010;
                    s_d.tel.obj = fdr_pkg::OBJ_SHADE;
                    s_d.tel.data = s_q.pend_data_1;
                end
                else if (s_q.pend[2])
                begin
                    take        = 3'b100;
                    s_d.tel.obj = fdr_pkg::OBJ_SLAT;
                    s_d.tel.data = s_q.pend_data_2;
                end
                if (take != 3'h0)
                begin
                    s_d.seq = fdr_pkg::SEQ_BUSY;
                end
            end
            fdr_pkg::SEQ_BUSY:
            begin
                if (tel_ready)
                begin
                    s_d.seq = fdr_pkg::SEQ_IDLE;
                end
            end
            default: s_d.seq = fdr_pkg::SEQ_IDLE;
        endcase

        // a new request in the cycle of the take wins over the clear
        s_d.pend = (s_q.pend & ~take) | set_pend;
        if (set_pend[0])
        begin
            s_d.pend_data_0 = set_data[7:0];
        end
        if (set_pend[1])
        begin
            s_d.pend_data_1 = set_data[15:8];
        end
        if (set_pend[2])
        begin
            s_d.pend_data_2 = set_data[23:16];
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q        <= '0;
            s_q.ctrl   <= fdr_pkg::fdr_ctrl_t'(fdr_pkg::CTRL_RST);
            s_q.startv <= '{sbit: fdr_pkg::SBIT_RST, slat: fdr_pkg::VAL_RST,
                            shade: fdr_pkg::VAL_RST, height: fdr_pkg::VAL_RST};
            s_q.endv   <= '{sbit: fdr_pkg::SBIT_RST, slat: fdr_pkg::VAL_RST,
                            shade: fdr_pkg::VAL_RST, height: fdr_pkg::VAL_RST};
            s_q.seq    <= fdr_pkg::SEQ_IDLE;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // outputs
    assign prdata    = s_q.prdata;
    assign tel       = s_q.tel;
    assign tel_valid = (s_q.seq == fdr_pkg::SEQ_BUSY);
    assign locked    = s_q.locked;

endmodule : fdr_facade_disable

// [fdr_facade_disable_sva.sv]
// checker for the facade disable response block: port relations over time
// assumes it is bound to fdr_facade_disable and sees only that module's ports
`timescale 1ns/1ps
module fdr_facade_disable_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              ce,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              dis_valid,
    input wire logic              dis_value,
    input wire logic [2:0]        auto_valid,
    input wire logic [7:0]        auto_height,
    input wire logic [7:0]        auto_shade,
    input wire logic [7:0]        auto_slat,
    input wire logic              tel_valid,
    input wire logic              tel_ready,
    input wire fdr_pkg::fdr_tel_t tel,
    input wire logic              locked
);
    // ************************************************************
    // telegram handshake, lock and apb relations
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // offered telegram still waiting, and telegram taken by the sink
    sequence s_wait;
        ce && tel_valid && !tel_ready;
    endsequence
    sequence s_accept;
        ce && tel_valid && tel_ready;
    endsequence

    property p_tel_hold;
        s_wait |=> tel_valid && $stable(tel);
    endproperty
    a_tel_hold: assert property (p_tel_hold) else $error("telegram moved before accept");
    property p_tel_gap;
        s_accept |=> !tel_valid;
    endproperty
    a_tel_gap: assert property (p_tel_gap) else $error("no idle cycle after telegram");
    property p_obj_legal;
        tel_valid |-> tel.obj != 2'h3;
    endproperty
    a_obj_legal: assert property (p_obj_legal) else $error("telegram on unknown object");
    property p_lock_cause;
        $rose(locked) |-> $past(dis_valid && ce);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without disable telegram");
    // a control write reaches the lock one cycle late, so the previous cycle counts as a cause too
    property p_lock_hold;
        !dis_valid && !(psel && penable && pwrite) && !$past(psel && penable && pwrite)
            |=> $stable(locked);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock moved without cause");
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
    property p_rd_load;
        $changed(prdata) |-> $past(psel && !penable && !pwrite);
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read data moved outside read setup");
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    c_accept: cover property (s_accept);
endmodule : fdr_facade_disable_sva

bind fdr_facade_disable fdr_facade_disable_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// [fdr_facade_disable_tb.sv]
// testbench for the facade disable response block
// assumes the design package is compiled first; checker binds itself
`timescale 1ns/1ps
module fdr_facade_disable_tb;
    // ************************************************************
    // signals, clock, instances
    // ************************************************************
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
    logic sys_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, dis_valid = 0, dis_value = 0, slow = 0;
    logic [2:0]  auto_valid = 3'h0;
    logic [7:0]  auto_height = 8'h00, auto_shade = 8'h00, auto_slat = 8'h00;
    logic        tel_valid, tel_ready, locked, err;
    fdr_pkg::fdr_tel_t tel;
    int          error_cnt = 0, num_checks = 0, cyc = 0;

    always #5 sys_clk = ~sys_clk;

    fdr_facade_disable #(.ADDR_W(8)) DUT (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .dis_valid(dis_valid),
        .dis_value(dis_value), .auto_valid(auto_valid), .auto_height(auto_height),
        .auto_shade(auto_shade), .auto_slat(auto_slat), .tel_valid(tel_valid),
        .tel_ready(tel_ready), .tel(tel), .locked(locked));
    fdr_bus_sink SINK (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
        .tel_valid(tel_valid), .tel(tel), .tel_ready(tel_ready));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // one apb transfer, released only after pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic v);
        @(posedge sys_clk);
        dis_valid <= 1'b1; dis_value <= v;
        @(posedge sys_clk);
        dis_valid <= 1'b0;
    endtask : pulse

    // let traffic settle, then check the number of telegrams logged
    task automatic settle(input int n);
        repeat (40) @(posedge sys_clk);
        `CHK(SINK.n_got, n)
    endtask : settle

    task automatic chk_tel(input int i, input logic [1:0] o, input logic [7:0] d);
        `CHK(SINK.got[i], {o, d})
    endtask : chk_tel

    // cycle ceiling against a hang
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        apb(0, fdr_pkg::CTRL_OFS, 0);   `CHK(rd, 32'h0)
        apb(0, fdr_pkg::STATUS_OFS, 0); `CHK(rd, 32'h0)
        apb(0, 8'h10, 0);               `CHK({err, rd}, 33'h100000000)
        apb(1, fdr_pkg::STARTV_OFS, 32'h0114327f);
        apb(0, fdr_pkg::STARTV_OFS, 0); `CHK(rd, 32'h01143264)
        apb(1, fdr_pkg::ENDV_OFS, 32'h00285a0a);
        apb(1, fdr_pkg::CTRL_OFS, 32'h000232bf);
        apb(0, fdr_pkg::CTRL_OFS, 0);   `CHK(rd, 32'h000232bf)
        // lock on one: configured start values in priority order
        pulse(1'b1);
        settle(3);                      `CHK(locked, 1'b1)
        chk_tel(0, fdr_pkg::OBJ_HEIGHT, 8'h64);
        chk_tel(1, fdr_pkg::OBJ_SHADE, 8'h32);
        chk_tel(2, fdr_pkg::OBJ_SLAT, 8'h14);
        // automatic update held back but tracked; repeat lock ignored
        @(posedge sys_clk);
        auto_valid <= 3'h1; auto_height <= 8'h33;
        @(posedge sys_clk);
        auto_valid <= 3'h0;
        pulse(1'b1);
        settle(3);
        // release with a stalling sink: tracked height, configured shade, no slat
        slow <= 1'b1;
        pulse(1'b0);
        settle(5);                      `CHK(locked, 1'b0)
        chk_tel(3, fdr_pkg::OBJ_HEIGHT, 8'h33);
        chk_tel(4, fdr_pkg::OBJ_SHADE, 8'h5a);
        slow <= 1'b0;
        // unlocked automatic slat update passes
        @(posedge sys_clk);
        auto_valid <= 3'h4; auto_slat <= 8'h07;
        @(posedge sys_clk);
        auto_valid <= 3'h0;
        settle(6);
        chk_tel(5, fdr_pkg::OBJ_SLAT, 8'h07);
        // lock on zero, 1-bit formats: height ignored, shading bit sent
        apb(1, fdr_pkg::CTRL_OFS, 32'h000200a8);
        pulse(1'b1);
        settle(6);                      `CHK(locked, 1'b0)
        pulse(1'b0);
        settle(7);                      `CHK(locked, 1'b1)
        chk_tel(6, fdr_pkg::OBJ_SHADE, 8'h01);
        pulse(1'b1);
        settle(7);                      `CHK(locked, 1'b0)
        // frozen clock enable loses the strobe; then a lock with no start action
        apb(1, fdr_pkg::CTRL_OFS, 32'h0002c011);
        ce <= 1'b0;
        pulse(1'b1);
        ce <= 1'b1;
        settle(7);                      `CHK(locked, 1'b0)
        pulse(1'b1);
        settle(7);                      `CHK(locked, 1'b1)
        // held-back shading bit tracked at release, configured slat sent
        @(posedge sys_clk);
        auto_valid <= 3'h2; auto_shade <= 8'h01;
        @(posedge sys_clk);
        auto_valid <= 3'h0;
        pulse(1'b0);
        settle(9);                      `CHK(locked, 1'b0)
        chk_tel(7, fdr_pkg::OBJ_SHADE, 8'h01);
        chk_tel(8, fdr_pkg::OBJ_SLAT, 8'h28);
        // control disabled: telegrams on the disable object ignored
        apb(1, fdr_pkg::CTRL_OFS, 32'h0);
        pulse(1'b1);
        settle(9);                      `CHK(locked, 1'b0)
        complete_run();
    end
endmodule : fdr_facade_disable_tb

// [fdr_pkg.sv]
// package for the facade disable response block: register map, field layout, types
// assumes an apb slave with 32-bit data and a telegram sink on the same clock
package fdr_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STARTV_OFS  = 8'h04;
    localparam logic [7:0] ENDV_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS  = 8'h0c;

    // ************************************************************
    // field layout of the value registers
    // ************************************************************
    localparam int HEIGHT_LSB = 0;
    localparam int SHADE_LSB  = 8;
    localparam int SLAT_LSB   = 16;
    localparam int SBIT_POS   = 24;
    localparam int CTRL_W     = 18;

    // percentage ceiling for every configured value
    localparam logic [6:0] PCT_MAX = 7'h64;

    // reset values
    localparam logic [17:0] CTRL_RST = 18'h00000;
    localparam logic [6:0]  VAL_RST  = 7'h00;
    localparam logic        SBIT_RST = 1'b0;

    // per-output choice codes
    localparam logic [1:0] CH_NONE  = 2'h0;
    localparam logic [1:0] CH_SEND  = 2'h1;
    localparam logic [1:0] CH_TRACK = 2'h2;

    // object selectors on the telegram port
    localparam logic [1:0] OBJ_HEIGHT = 2'h0;
    localparam logic [1:0] OBJ_SHADE  = 2'h1;
    localparam logic [1:0] OBJ_SLAT   = 2'h2;

    // control register, msb first; bit 0 is the lock polarity
    typedef struct packed {
        logic       enable;      // 17: facade disable control present
        logic [1:0] end_slat;    // 16:15
        logic [1:0] end_shade;   // 14:13
        logic [1:0] end_height;  // 12:11
        logic [1:0] st_slat;     // 10:9
        logic [1:0] st_shade;    // 8:7
        logic [1:0] st_height;   // 6:5
        logic       end_cfg;     // 4: send configured state at end
        logic       st_cfg;      // 3: send configured state at start
        logic       shade_byte;  // 2: shading object is 1-byte
        logic       height_byte; // 1: height object is 1-byte
        logic       lock_on_one; // 0: lock on 1-telegram
    } fdr_ctrl_t;

    // configured values for one edge of the lock
    typedef struct packed {
        logic       sbit;
        logic [6:0] slat;
        logic [6:0] shade;
        logic [6:0] height;
    } fdr_vals_t;

    // telegram toward the bus
    typedef struct packed {
        logic [1:0] obj;
        logic [7:0] data;
    } fdr_tel_t;

    // one-hot send sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } fdr_seq_t;

    // whole state of the block
    typedef struct packed {
        fdr_ctrl_t  ctrl;
        fdr_vals_t  startv;
        fdr_vals_t  endv;
        logic       locked;
        logic [7:0] cur_height;
        logic [7:0] cur_shade;
        logic [7:0] cur_slat;
        logic [2:0] pend;
        logic [7:0] pend_data_0;
        logic [7:0] pend_data_1;
        logic [7:0] pend_data_2;
        fdr_seq_t   seq;
        fdr_tel_t   tel;
        logic [31:0] prdata;
    } fdr_state_t;

endpackage : fdr_pkg
